// [dv/tb_usr_core.sv]
// Self-checking bench for the serial data path
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_usr_core import usr_pkg::*;;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  usr_bus_s bus = '0;
  logic [7:0] rdata;
  logic rxdIn, txdOut, txdOe, rxdOwn, xckOut, xckOe, emptyIrq, txDoneIrq, txdPin;
  logic txDoneAck = 1'b0;
  int n_fail = 0;
  int tests_run = 0;
  int txQ[$];
  int rxQ[$];
  always #10 mclk = ~mclk;
  // Pull-up on the output pin when not driven
  assign txdPin = txdOe ? txdOut : 1'b1;
  usr_core uut (.mclk(mclk), .rst_b(rst_b), .busIn(bus), .rdata(rdata), .rxdIn(rxdIn),
    .txdOut(txdOut), .txdOe(txdOe), .rxdOwn(rxdOwn), .xckIn(1'b0), .xckOut(xckOut),
    .xckOe(xckOe), .txDoneAck(txDoneAck), .emptyIrq(emptyIrq), .txDoneIrq(txDoneIrq));
  usr_remote rem (.mclk(mclk), .txdPin(txdPin), .rxdPin(rxdIn));
  // ----------------------------------------
  // Register port and checking tasks
  // ----------------------------------------
  task automatic regWr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{adr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '0;
    #1;
  endtask
  task automatic regRd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus <= '{adr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '0;
    #1 d = rdata;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic waitCsa(input int bitNo, output logic [7:0] v);
    int w;
    w = 0;
    regRd(ADR_CSA, v);
    while (v[bitNo] !== 1'b1) begin
      w++;
      if (w > 500) begin
        n_fail++;
        print_verdict();
      end
      regRd(ADR_CSA, v);
    end
  endtask
  task automatic rxCheck(input int nb);
    logic [7:0] v;
    logic [8:0] got;
    int x;
    regRd(ADR_CSB, v);
    got[8] = (nb == 9) ? v[CSB_RXB8] : 1'b0;
    regRd(ADR_DATA, v);
    got[7:0] = v;
    x = rxQ.pop_front();
    `CHK("rx data", 9'(x), got)
  endtask
  task automatic txCheck(input int nb, input int pm, input int ns);
    logic [8:0] got;
    logic p;
    logic ok;
    int x;
    rem.getFrame(nb, pm != 0, ns, got, p, ok);
    x = txQ.pop_front();
    `CHK("tx framing", 1'b1, ok)
    `CHK("tx data", 9'(x), got)
    if (pm != 0) `CHK("tx parity", (pm == 2) ^ (^(9'(x))), p)
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    print_verdict();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] v;
    logic [8:0] d;
    int code, nb, pm, ns;
    void'($urandom(32'hB4E6));
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    #1;
    `CHK("idle line", 1'b1, txdOut)
    `CHK("pin owner", 1'b0, txdOe)
    regRd(ADR_CSA, v);
    `CHK("status reset", 8'h20, v)
    regRd(ADR_CSC, v);
    `CHK("format reset", CSC_RST, v)
    regRd(3'h6, v);
    `CHK("unmapped", 8'h00, v)
    regWr(ADR_CSC, 8'hC6);
    regWr(ADR_CSB, 8'h08);
    @(posedge mclk);
    #1;
    `CHK("clock pin", 1'b1, xckOe)
    v[0] = xckOut;
    @(posedge mclk);
    #1;
    `CHK("clock toggles", ~v[0], xckOut)
    for (int f = 0; f < 5; f++) begin
      code = (f < 4) ? f : 7;
      nb = (f < 4) ? f + 5 : 9;
      pm = f % 3;
      ns = (f % 2) + 1;
      rem.bitClk = (f == 4) ? 8 : 16;
      regWr(ADR_CSA, {6'h00, f == 4, 1'b0});
      regWr(ADR_CSC, {2'b00, pm != 0, pm == 2, ns == 2, 2'(code), 1'b0});
      d = 9'($urandom);
      regWr(ADR_CSB, {3'b000, 2'b11, 1'(code >> 2), 1'b0, d[8]});
      regWr(ADR_DATA, d[7:0]);
      `CHK("pins owned", 3'b110, {txdOe, rxdOwn, xckOe})
      txQ.push_back(int'(d) & ((1 << nb) - 1));
      txCheck(nb, pm, ns);
      d = 9'($urandom);
      rxQ.push_back(int'(d) & ((1 << nb) - 1));
      rem.sendFrame(d, nb, pm != 0, pm == 2, ns);
      waitCsa(CSA_RXC, v);
      `CHK("rx errors", 2'b00, {v[CSA_FE], v[CSA_PE]})
      rxCheck(nb);
      regRd(ADR_CSA, v);
      `CHK("rx empty", 1'b0, v[CSA_RXC])
    end
    for (int i = 0; i < 3; i++) begin
      d = 9'($urandom);
      if (i < 2) rxQ.push_back(int'(d));
      rem.sendFrame(d, 9, 1'b1, 1'b0, 1);
    end
    rxCheck(9);
    rxCheck(9);
    regRd(ADR_CSA, v);
    `CHK("third dropped", 1'b0, v[CSA_RXC])
    `CHK("done flag", 1'b1, v[CSA_TXC])
    regWr(ADR_CSA, 8'h40);
    rem.bitClk = 16;
    regRd(ADR_CSA, v);
    `CHK("done cleared", 1'b0, v[CSA_TXC])
    regWr(ADR_CSB, 8'h78);
    repeat (2) @(posedge mclk);
    #1;
    `CHK("empty request", 1'b1, emptyIrq)
    for (int i = 0; i < 2; i++) begin
      waitCsa(CSA_DATA_REGISTER_EMPTY_FLAG, v);
      d = 9'($urandom);
      regWr(ADR_DATA, d[7:0]);
      txQ.push_back(int'(d[7:0]));
    end
    regRd(ADR_CSA, v);
    `CHK("buffer full", 1'b0, v[CSA_DATA_REGISTER_EMPTY_FLAG])
    `CHK("empty request", 1'b0, emptyIrq)
    regWr(ADR_CSB, 8'h50);
    txCheck(8, 1, 1);
    `CHK("held owner", 1'b1, txdOe)
    regRd(ADR_CSA, v);
    `CHK("done early", 1'b0, v[CSA_TXC])
    txCheck(8, 1, 1);
    repeat (20) @(posedge mclk);
    #1;
    `CHK("done request", 1'b1, txDoneIrq)
    `CHK("released", 1'b0, txdOe)
    `CHK("request masked", 1'b0, emptyIrq)
    regWr(ADR_CSA, 8'h00);
    regRd(ADR_CSA, v);
    `CHK("zero kept", 1'b1, v[CSA_TXC])
    @(posedge mclk);
    txDoneAck <= 1'b1;
    @(posedge mclk);
    txDoneAck <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    `CHK("ack clears", 1'b0, txDoneIrq)
    print_verdict();
  end
endmodule

// [dv/usr_remote.sv]
// Remote serial transceiver model facing the transmit and receive pins
`timescale 1ns/10ps
module usr_remote (
  // Clock
  input wire logic mclk,
  // Serial lines
  input wire logic txdPin,
  output logic rxdPin
);
  int bitClk = 16;
  initial rxdPin = 1'b1;
  // ----------------------------------------
  // Send one frame, line left high after
  // ----------------------------------------
  task automatic sendFrame(input logic [8:0] d, input int nb, input logic pe,
                           input logic odd, input int ns);
    logic bits[$];
    bits = {1'b0};
    for (int i = 0; i < nb; i++) bits.push_back(d[i]);
    if (pe) bits.push_back(odd ^ (^(d & 9'((1 << nb) - 1))));
    for (int i = 0; i < ns; i++) bits.push_back(1'b1);
    foreach (bits[i]) begin
      @(posedge mclk);
      rxdPin <= bits[i];
      repeat (bitClk - 1) @(posedge mclk);
    end
  endtask
  // ----------------------------------------
  // Capture one frame at mid-bit
  // ----------------------------------------
  task automatic getFrame(input int nb, input logic pe, input int ns,
                          output logic [8:0] d, output logic p, output logic ok);
    int w;
    d = '0;
    p = 1'b0;
    ok = 1'b0;
    w = 0;
    while (txdPin !== 1'b0 && w < 400) begin
      @(posedge mclk);
      w++;
    end
    if (w >= 400) return;
    repeat (bitClk / 2) @(posedge mclk);
    ok = (txdPin === 1'b0);
    for (int i = 0; i < nb; i++) begin
      repeat (bitClk) @(posedge mclk);
      d[i] = txdPin;
    end
    if (pe) begin
      repeat (bitClk) @(posedge mclk);
      p = txdPin;
    end
    for (int i = 0; i < ns; i++) begin
      repeat (bitClk) @(posedge mclk);
      ok &= (txdPin === 1'b1);
    end
  endtask
endmodule

// [pkg/usr_pkg.sv]
// Shared constants and types for the serial transmit and receive data path
package usr_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] ADR_DATA = 3'h0;
  localparam logic [2:0] ADR_CSA = 3'h1;
  localparam logic [2:0] ADR_CSB = 3'h2;
  localparam logic [2:0] ADR_CSC = 3'h3;
  localparam logic [2:0] ADR_BAUDL = 3'h4;
  localparam logic [2:0] ADR_BAUDH = 3'h5;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CSA_RXC = 7;
  localparam int CSA_TXC = 6;
  localparam int CSA_DATA_REGISTER_EMPTY_FLAG = 5;
  localparam int CSA_FE = 4;
  localparam int CSA_PE = 2;
  localparam int CSA_U2X = 1;
  localparam int CSB_TRANSMIT_COMPLETE_INTERRUPT_ENABLE = 6;
  localparam int CSB_EMPTY_INTERRUPT_ENABLE = 5;
  localparam int CSB_RECEIVER_ENABLE = 4;
  localparam int CSB_TRANSMITTER_ENABLE = 3;
  localparam int CSB_SIZE2 = 2;
  localparam int CSB_RXB8 = 1;
  localparam int CSB_TRANSMIT_NINTH_BIT = 0;
  localparam int CSC_MASTER = 7;
  localparam int CSC_SYNC = 6;
  localparam int CSC_PAR_HI = 5;
  localparam int CSC_PAR_LO = 4;
  localparam int CSC_STOP2 = 3;
  localparam int CSC_SIZE_HI = 2;
  localparam int CSC_SIZE_LO = 1;
  localparam int CSC_POL = 0;
  localparam int RXW_FE = 10;
  localparam int RXW_PE = 9;
  localparam int RX_WORD_W = 11;
  localparam int RX_DEPTH_DEF = 2;
  // ---------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [7:0] CSC_RST = 8'h06;
  localparam logic [11:0] BAUD_RST = 12'h000;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [4:0] OVS_NORMAL = 5'h10;
  localparam logic [4:0] OVS_DOUBLE = 5'h08;
  localparam logic [12:0] FRAME_ONES = 13'h1FFF;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] adr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } usr_bus_s;
  typedef struct packed {
    logic [11:0] ubrr;
    logic u2x;
    logic sync;
    logic master;
    logic pol;
  } usr_cfg_s;
  typedef enum {RX_IDLE, RX_START, RX_BITS, RX_STOP} usr_rx_e;
  // Data bits per character from the size code
  function automatic logic [3:0] usr_char_bits(input logic [2:0] code);
    case (code)
      3'h0: usr_char_bits = 4'h5;
      3'h1: usr_char_bits = 4'h6;
      3'h2: usr_char_bits = 4'h7;
      SIZE_NINE: usr_char_bits = 4'h9;
      default: usr_char_bits = 4'h8;
    endcase
  endfunction
endpackage

// [rtl/usr_baud.sv]
// Bit timing: baud divider, oversampling and external clock handling
`timescale 1ns/10ps
module usr_baud
  import usr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Rate and mode
  input wire usr_cfg_s cfg,
  // External clock pin
  input wire logic xckIn,
  output logic xckOut,
  // Timing pulses
  output logic txStep,
  output logic rxTick
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic [11:0] cnt;
    logic [4:0] ovs;
    logic external_transfer_clock_pin;
    logic txStep;
    logic rxTick;
  } usr_baud_s;
  usr_baud_s st, next_st;
  logic [4:0] ovsLen;
  logic tick, rise, fall;

  always_comb begin
    next_st = st;
    ovsLen = cfg.u2x ? OVS_DOUBLE : OVS_NORMAL;
    tick = (st.cnt == 12'h000);
    next_st.cnt = tick ? cfg.ubrr : st.cnt - 12'h001;
    next_st.s1 = xckIn;
    next_st.s2 = st.s1;
    next_st.prev = st.s2;
    if (tick) begin
      next_st.external_transfer_clock_pin = ~st.external_transfer_clock_pin;
      // Wrap at once when the rate shrinks below the current count
      next_st.ovs = (st.ovs >= ovsLen - 5'h01) ? 5'h00 : st.ovs + 5'h01;
    end
    // Master makes its own edges, slave follows the synchronised pin
    rise = cfg.master ? (tick & ~st.external_transfer_clock_pin) : (st.s2 & ~st.prev);
    fall = cfg.master ? (tick & st.external_transfer_clock_pin) : (~st.s2 & st.prev);
    next_st.txStep = cfg.sync ? (cfg.pol ? fall : rise)
                              : (tick && st.ovs == ovsLen - 5'h01);
    next_st.rxTick = cfg.sync ? (cfg.pol ? rise : fall) : tick;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign xckOut = st.external_transfer_clock_pin;
  assign txStep = st.txStep;
  assign rxTick = st.rxTick;
endmodule

// [rtl/usr_core.sv]
// Serial transmit and receive data path with its register port
`timescale 1ns/10ps
// Function
// - Transmitter enable hands output pin to transmitter
// - Synchronous mode uses external clock pin
// - Data write fills buffer; loads when idle
// - Shift register sends frame at bit rate
// - Unused upper data bits ignored on transmit
// - Ninth bit sent from control bit
// - Empty flag shows transmit buffer empty
// - Empty request while flag and enable set
// - Complete flag set when frame and buffer done
// - Complete flag cleared by ack or one
// - Complete request while flag and enable set
// - Parity bit after data, before stop
// - Disable waits until shift and buffer empty
// - Receiver enable hands input pin to receiver
// - Start bit begins frame, bits shifted in
// - Second stop bit ignored by receiver
// - First stop bit moves frame into buffer
// - Unused upper bits read as zero
// - Start low, data LSB first, stops high
// - Parity is xor, inverted for odd
// - Receive flag shows unread data present
// - Receive buffer holds two characters
module usr_core
  import usr_pkg::*;
#(
  parameter int RX_DEPTH = RX_DEPTH_DEF
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire usr_bus_s busIn,
  output logic [7:0] rdata,
  // Serial pins
  input wire logic rxdIn,
  output logic txdOut,
  output logic txdOe,
  output logic rxdOwn,
  input wire logic xckIn,
  output logic xckOut,
  output logic xckOe,
  // Interrupt requests
  input wire logic txDoneAck,
  output logic emptyIrq,
  output logic txDoneIrq
);
  typedef struct packed {
    logic transmit_complete_interrupt_enable;
    logic empty_interrupt_enable;
    logic receiver_enable;
    logic transmitter_enable;
    logic size2;
    logic transmit_ninth_bit;
    logic u2x;
    logic [7:0] csc;
    logic [11:0] ubrr;
    logic [7:0] bufData;
    logic buf9;
    logic bufFull;
    logic transmit_complete_flag;
    logic [12:0] frame;
    logic [3:0] rem;
    logic txOwn;
    logic txd;
    logic xckOe;
    logic rxOwn;
    logic emptyIrq;
    logic txDoneIrq;
    logic [7:0] rdata;
    logic rxS1;
    logic rxS2;
    usr_rx_e rxSt;
    logic [4:0] rxCnt;
    logic [3:0] rxLeft;
    logic [9:0] rxShift;
  } usr_core_s;
  usr_core_s st, next_st;

  usr_cfg_s cfg;
  logic txStep, rxTick, xckPin;
  logic [3:0] nBits, txLen, rxM;
  logic parEn, parOdd, load, txcSet, push, pop, rxValid, rxFull, rxIn;
  logic [8:0] mask9, txWord, rxData9;
  logic txPar, rxPe;
  logic [12:0] txFrame;
  logic [9:0] rxAligned;
  logic [4:0] ovsLen, half;
  logic [RX_WORD_W-1:0] rxHead, pushData;
  logic wrData, wrA, wrB, rdData;

  // ---------------------------------------------------------------
  // Bit timing and receive buffer
  // ---------------------------------------------------------------
  assign cfg = '{ubrr: st.ubrr, u2x: st.u2x, sync: st.csc[CSC_SYNC],
                 master: st.csc[CSC_MASTER], pol: st.csc[CSC_POL]};

  usr_baud u_baud (
    .mclk(mclk),
    .rst_b(rst_b),
    .cfg(cfg),
    .xckIn(xckIn),
    .xckOut(xckPin),
    .txStep(txStep),
    .rxTick(rxTick)
  );

  usr_rxbuf #(.W(RX_WORD_W), .DEPTH(RX_DEPTH)) u_rxbuf (
    .mclk(mclk),
    .rst_b(rst_b),
    .push(push),
    .pushData(pushData),
    .pop(pop),
    .flush(~st.receiver_enable),
    .head(rxHead),
    .notEmpty(rxValid),
    .full(rxFull)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    wrData = busIn.wr && busIn.adr == ADR_DATA;
    wrA = busIn.wr && busIn.adr == ADR_CSA;
    wrB = busIn.wr && busIn.adr == ADR_CSB;
    rdData = busIn.rd && busIn.adr == ADR_DATA;
    nBits = usr_char_bits({st.size2, st.csc[CSC_SIZE_HI:CSC_SIZE_LO]});
    parEn = st.csc[CSC_PAR_HI];
    parOdd = st.csc[CSC_PAR_LO];
    mask9 = 9'h1FF >> (4'h9 - nBits);
    // Frame assembly from the buffer
    txWord = {st.buf9, st.bufData} & mask9;
    txPar = ^txWord ^ parOdd;
    txFrame = (FRAME_ONES << (nBits + 4'h1)) | 13'({txWord, 1'b0});
    if (parEn) begin
      txFrame[nBits + 4'h1] = txPar;
    end
    txLen = 4'h1 + nBits + {3'h0, parEn} + (st.csc[CSC_STOP2] ? 4'h2 : 4'h1);
    load = 1'b0;
    txcSet = 1'b0;
    // Transmit shifting
    if (txStep) begin
      if (st.rem > 4'h1) begin
        next_st.frame = {1'b1, st.frame[12:1]};
        next_st.rem = st.rem - 4'h1;
      end else if (st.bufFull && st.txOwn) begin
        load = 1'b1;
        next_st.frame = txFrame;
        next_st.rem = txLen;
      end else begin
        txcSet = (st.rem == 4'h1);
        next_st.rem = 4'h0;
      end
    end
    if (load) begin
      next_st.bufFull = 1'b0;
    end
    if (wrData) begin
      next_st.bufData = busIn.wdata;
      next_st.buf9 = st.transmit_ninth_bit;
      next_st.bufFull = 1'b1;
    end
    if (txDoneAck || (wrA && busIn.wdata[CSA_TXC])) begin
      next_st.transmit_complete_flag = 1'b0;
    end
    if (txcSet) begin
      next_st.transmit_complete_flag = 1'b1;
    end
    // Receive framing
    rxIn = st.rxS2;
    next_st.rxS1 = rxdIn;
    next_st.rxS2 = st.rxS1;
    rxM = nBits + {3'h0, parEn};
    ovsLen = cfg.sync ? 5'h01 : (st.u2x ? OVS_DOUBLE : OVS_NORMAL);
    half = cfg.sync ? 5'h01 : (ovsLen >> 1);
    rxAligned = st.rxShift >> (4'hA - rxM);
    rxData9 = rxAligned[8:0] & mask9;
    rxPe = parEn & (^rxData9 ^ parOdd ^ rxAligned[nBits]);
    pushData = {~rxIn, rxPe, rxData9};
    push = 1'b0;
    if (!st.receiver_enable) begin
      next_st.rxSt = RX_IDLE;
    end else if (rxTick) begin
      unique case (st.rxSt)
        RX_IDLE: begin
          if (!rxIn) begin
            next_st.rxCnt = 5'h00;
            next_st.rxLeft = rxM;
            next_st.rxSt = cfg.sync ? RX_BITS : RX_START;
          end
        end
        RX_START: begin
          if (st.rxCnt == half - 5'h01) begin
            next_st.rxCnt = 5'h00;
            next_st.rxSt = rxIn ? RX_IDLE : RX_BITS;
          end else begin
            next_st.rxCnt = st.rxCnt + 5'h01;
          end
        end
        RX_BITS: begin
          if (st.rxCnt == ovsLen - 5'h01) begin
            next_st.rxCnt = 5'h00;
            next_st.rxShift = {rxIn, st.rxShift[9:1]};
            next_st.rxLeft = st.rxLeft - 4'h1;
            if (st.rxLeft == 4'h1) begin
              next_st.rxSt = RX_STOP;
            end
          end else begin
            next_st.rxCnt = st.rxCnt + 5'h01;
          end
        end
        RX_STOP: begin
          if (st.rxCnt == ovsLen - 5'h01) begin
            push = 1'b1;
            next_st.rxSt = RX_IDLE;
          end else begin
            next_st.rxCnt = st.rxCnt + 5'h01;
          end
        end
      endcase
    end
    // Register reads, answered in the following cycle
    pop = rdData && rxValid;
    next_st.rdata = 8'h00;
    if (busIn.rd) begin
      case (busIn.adr)
        ADR_DATA: next_st.rdata = rxHead[7:0];
        ADR_CSA: begin
          next_st.rdata[CSA_RXC] = rxValid;
          next_st.rdata[CSA_TXC] = st.transmit_complete_flag;
          next_st.rdata[CSA_DATA_REGISTER_EMPTY_FLAG] = ~st.bufFull;
          next_st.rdata[CSA_FE] = rxValid & rxHead[RXW_FE];
          next_st.rdata[CSA_PE] = rxValid & rxHead[RXW_PE];
          next_st.rdata[CSA_U2X] = st.u2x;
        end
        ADR_CSB: begin
          next_st.rdata[CSB_TRANSMIT_COMPLETE_INTERRUPT_ENABLE] = st.transmit_complete_interrupt_enable;
          next_st.rdata[CSB_EMPTY_INTERRUPT_ENABLE] = st.empty_interrupt_enable;
          next_st.rdata[CSB_RECEIVER_ENABLE] = st.receiver_enable;
          next_st.rdata[CSB_TRANSMITTER_ENABLE] = st.transmitter_enable;
          next_st.rdata[CSB_SIZE2] = st.size2;
          next_st.rdata[CSB_RXB8] = rxValid & rxHead[8];
          next_st.rdata[CSB_TRANSMIT_NINTH_BIT] = st.transmit_ninth_bit;
        end
        ADR_CSC: next_st.rdata = st.csc;
        ADR_BAUDL: next_st.rdata = st.ubrr[7:0];
        ADR_BAUDH: next_st.rdata = {4'h0, st.ubrr[11:8]};
        default: next_st.rdata = 8'h00;
      endcase
    end
    // Register writes
    if (wrA) begin
      next_st.u2x = busIn.wdata[CSA_U2X];
    end
    if (wrB) begin
      next_st.transmit_complete_interrupt_enable = busIn.wdata[CSB_TRANSMIT_COMPLETE_INTERRUPT_ENABLE];
      next_st.empty_interrupt_enable = busIn.wdata[CSB_EMPTY_INTERRUPT_ENABLE];
      next_st.receiver_enable = busIn.wdata[CSB_RECEIVER_ENABLE];
      next_st.transmitter_enable = busIn.wdata[CSB_TRANSMITTER_ENABLE];
      next_st.size2 = busIn.wdata[CSB_SIZE2];
      next_st.transmit_ninth_bit = busIn.wdata[CSB_TRANSMIT_NINTH_BIT];
    end
    if (busIn.wr && busIn.adr == ADR_CSC) begin
      next_st.csc = busIn.wdata;
    end
    if (busIn.wr && busIn.adr == ADR_BAUDL) begin
      next_st.ubrr[7:0] = busIn.wdata;
    end
    if (busIn.wr && busIn.adr == ADR_BAUDH) begin
      next_st.ubrr[11:8] = busIn.wdata[3:0];
    end
    // Pin ownership and requests
    next_st.txOwn = st.transmitter_enable | (st.txOwn & (st.rem != 4'h0 | st.bufFull));
    next_st.txd = (next_st.rem != 4'h0) ? next_st.frame[0] : 1'b1;
    next_st.xckOe = cfg.sync & cfg.master & (st.transmitter_enable | st.receiver_enable);
    next_st.rxOwn = st.receiver_enable;
    next_st.emptyIrq = next_st.empty_interrupt_enable & ~next_st.bufFull;
    next_st.txDoneIrq = next_st.transmit_complete_interrupt_enable & next_st.transmit_complete_flag;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.csc <= CSC_RST;
      st.ubrr <= BAUD_RST;
      st.txd <= 1'b1;
      st.rxS1 <= 1'b1;
      st.rxS2 <= 1'b1;
      st.rxSt <= RX_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rdata = st.rdata;
  assign txdOut = st.txd;
  assign txdOe = st.txOwn;
  assign rxdOwn = st.rxOwn;
  assign xckOut = xckPin;
  assign xckOe = st.xckOe;
  assign emptyIrq = st.emptyIrq;
  assign txDoneIrq = st.txDoneIrq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_txd_takeover: assert property (@(posedge mclk) disable iff (!rst_b)
    wrB && busIn.wdata[CSB_TRANSMITTER_ENABLE] |-> ##2 txdOe)
    else $error("transmit pin not taken over after enable");
  a_buf_filled: assert property (@(posedge mclk) disable iff (!rst_b)
    wrData |=> st.bufFull)
    else $error("buffer not full after data write");
  a_load_start: assert property (@(posedge mclk) disable iff (!rst_b)
    load |=> !txdOut && st.rem == $past(txLen))
    else $error("load did not start a frame");
  a_txc_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    wrA && busIn.wdata[CSA_TXC] && !txcSet |=> !st.transmit_complete_flag)
    else $error("complete flag not cleared by write of one");
  a_txc_set: assert property (@(posedge mclk) disable iff (!rst_b)
    txcSet |=> st.transmit_complete_flag && !st.bufFull ##0 txdOut)
    else $error("complete flag not set at frame end");
  a_txc_irq: assert property (@(posedge mclk) disable iff (!rst_b)
    st.transmit_complete_interrupt_enable && st.transmit_complete_flag |-> txDoneIrq)
    else $error("complete request missing");
  a_empty_irq: assert property (@(posedge mclk) disable iff (!rst_b)
    st.empty_interrupt_enable && !st.bufFull |-> emptyIrq)
    else $error("empty request missing");
  a_disable_wait: assert property (@(posedge mclk) disable iff (!rst_b)
    !st.transmitter_enable && (st.rem != 4'h0 || st.bufFull) |=> txdOe)
    else $error("transmit pin released before frames done");
  a_rx_store: assert property (@(posedge mclk) disable iff (!rst_b)
    push && !rxFull && st.receiver_enable && !(wrB && !busIn.wdata[CSB_RECEIVER_ENABLE]) |=> rxValid)
    else $error("received frame not stored");
  a_rx_mask: assert property (@(posedge mclk) disable iff (!rst_b)
    rdData && nBits == 4'h5 |=> rdata[7:5] == 3'h0)
    else $error("unused received bits not zero");
  a_rx_own: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(st.receiver_enable) |=> rxdOwn)
    else $error("receive pin not taken over");
endmodule

// [rtl/usr_rxbuf.sv]
// Receive buffer: small first-in first-out store with flush
`timescale 1ns/10ps
module usr_rxbuf
  import usr_pkg::*;
#(
  parameter int W = RX_WORD_W,
  parameter int DEPTH = RX_DEPTH_DEF
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Fill, drain and flush
  input wire logic push,
  input wire logic [W-1:0] pushData,
  input wire logic pop,
  input wire logic flush,
  // Status
  output logic [W-1:0] head,
  output logic notEmpty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2) begin : g_bad_depth
    $error("usr_rxbuf needs a depth of at least two");
  end
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] rdPtr;
    logic [AW-1:0] wrPtr;
    logic [AW:0] count;
  } usr_rxbuf_s;
  usr_rxbuf_s st, next_st;
  logic doPush, doPop;

  always_comb begin
    next_st = st;
    doPop = pop && st.count != '0;
    doPush = push && st.count != (AW+1)'(DEPTH);
    if (doPush) begin
      next_st.mem[st.wrPtr] = pushData;
      next_st.wrPtr = (st.wrPtr == AW'(DEPTH - 1)) ? '0 : st.wrPtr + 1'b1;
    end
    if (doPop) begin
      next_st.rdPtr = (st.rdPtr == AW'(DEPTH - 1)) ? '0 : st.rdPtr + 1'b1;
    end
    next_st.count = st.count + (AW+1)'(doPush) - (AW+1)'(doPop);
    if (flush) begin
      next_st.rdPtr = '0;
      next_st.wrPtr = '0;
      next_st.count = '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign head = st.mem[st.rdPtr];
  assign notEmpty = (st.count != '0);
  assign full = (st.count == (AW+1)'(DEPTH));
endmodule
